/* rtl/ncpe_host.v */
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "ncpe_regs.vh"

module ncpe_host
(
  // Clock and reset.
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave.
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Flash pins.
  output wire        ce_n_o,
  output wire        cle_o,
  output wire        ale_o,
  output wire        we_n_o,
  output wire        re_n_o,
  output wire        wp_n_o,
  output wire [7:0]  io_o,
  output wire        io_oe_o,
  input  wire [7:0]  io_i,
  input  wire        rb_n_i
);

  // ---------------------------------------------------------------------------
  // Sequencer states.
  // ---------------------------------------------------------------------------
  localparam S_IDLE = 3'd0;  // Nothing in flight.
  localparam S_CMD  = 3'd1;  // Command latch cycle.
  localparam S_ADDR = 3'd2;  // Address latch cycles.
  localparam S_DATA = 3'd3;  // Waiting for the next data byte from software.
  localparam S_DOUT = 3'd4;  // Data write cycle.
  localparam S_TWB  = 3'd5;  // Gap before the busy line is trusted.
  localparam S_RB   = 3'd6;  // Waiting for the busy line to release.
  localparam S_STAT = 3'd7;  // Status read cycle.

  reg  [2:0]  state;     // Sequencer state.
  reg         ph;        // Strobe phase: 0 strobe low, 1 strobe high.
  reg  [3:0]  tcnt;      // Cycle counter inside a phase.
  reg  [7:0]  cmd_q;     // Command byte being sent.
  reg  [7:0]  pend_cmd;  // Command held back while the idle flag is polled.
  reg  [1:0]  acnt;      // Address byte index.
  reg  [31:0] addr_q;    // Column bytes 0-1, row bytes 2-3.
  reg  [7:0]  dat_q;     // Data byte being written.
  reg  [7:0]  stat_q;    // Last captured device status byte.
  reg  [11:0] dcnt;      // Bytes loaded into the current page.
  reg  [6:0]  pcnt;      // Pages queued in the current cache sequence.
  reg  [9:0]  blk_q;     // Block of the current cache sequence.
  reg         loading;   // Page data phase is open.
  reg         in_seq;    // A cache sequence is open.
  reg         pend_idle; // A cache confirm ended the last transfer.
  reg         polling;   // Status reads poll for the idle flag.
  reg         dev_rst;   // Device sits in its reset condition.
  reg         err;       // Sticky refusal flag, cleared by a status read.
  reg         wp_en;     // Write-protect pin driven active.
  reg  [2:0]  rb_s;      // Busy line synchroniser.
  reg  [7:0]  io_a, io_b, io_c; // Data bus synchroniser.
  reg         rb_q;      // Debounced busy line, high when ready.

  // ---------------------------------------------------------------------------
  // Strobe timing helpers.
  // ---------------------------------------------------------------------------
  // Phase lengths minus one; only the low bits reach the phase counter.
  localparam [31:0] WLO_M1 = `NCPE_T_WLO_CYC - 1;
  localparam [31:0] WHI_M1 = `NCPE_T_WHI_CYC - 1;
  localparam [31:0] RLO_M1 = `NCPE_T_RLO_CYC - 1;
  localparam [31:0] WB_M1  = `NCPE_T_WB_CYC - 1;

  // Returns the number of cycles of the current phase minus one.
  function [3:0] ph_len;
    input [2:0] st;
    input       p;
    begin
      if (p)
        ph_len = WHI_M1[3:0];
      else if (st == S_STAT)
        ph_len = RLO_M1[3:0];
      else
        ph_len = WLO_M1[3:0];
    end
  endfunction

  wire strobing = (state == S_CMD) || (state == S_ADDR) || (state == S_DOUT);
  wire io_ok    = (io_b == io_c);             // Bus byte has settled.
  wire ph_end   = (tcnt == ph_len(state, ph)) && !((state == S_STAT) && !ph && !io_ok);
  wire cyc_done = ph && ph_end;               // Whole pin cycle finished.

  // ---------------------------------------------------------------------------
  // Pin drive, all from registered state.
  // ---------------------------------------------------------------------------
  assign ce_n_o  = (state == S_IDLE) && !loading;
  assign cle_o   = (state == S_CMD);
  assign ale_o   = (state == S_ADDR);
  assign we_n_o  = !(strobing && !ph);
  assign re_n_o  = !((state == S_STAT) && !ph);
  assign wp_n_o  = !wp_en;
  assign io_oe_o = strobing;
  assign io_o    = (state == S_CMD)  ? cmd_q :
                   (state == S_ADDR) ? addr_q[{acnt, 3'b000} +: 8] : dat_q;

  // ---------------------------------------------------------------------------
  // Bus decode.
  // ---------------------------------------------------------------------------
  wire       req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire       wr     = req && wb_we_i && wb_sel_i[0];
  wire       d_wr   = wr && (wb_adr_i == `NCPE_DATA_OFS);
  wire       c_wr   = wr && (wb_adr_i == `NCPE_CTRL_OFS);
  wire [2:0] op     = wb_dat_i[`NCPE_CTRL_OP_MSB:`NCPE_CTRL_OP_LSB];
  // A data write stalls while a data cycle is on the pins.
  wire       d_hold = d_wr && loading && (state != S_DATA);
  wire       idle   = (state == S_IDLE);
  wire [9:0] blk_in = addr_q[31:22];   // Block of the page about to be set up.

  // Accepted control requests.
  wire go_setup = (op == `NCPE_OP_SETUP) && idle && (!in_seq ||
                  ((blk_in == blk_q) && (pcnt < `NCPE_MAX_PAGES)));
  wire go_conf  = ((op == `NCPE_OP_CACHE) || (op == `NCPE_OP_LAST)) &&
                  (state == S_DATA) && (dcnt != 12'd0);
  // A sequence closed by a cache confirm may be followed by an erase that polls first.
  wire go_erase = (op == `NCPE_OP_ERASE) && idle && (!in_seq || pend_idle);
  wire go_rst   = (op == `NCPE_OP_RESET) && !dev_rst;
  wire go_stat  = (op == `NCPE_OP_STATUS) && idle;

  // ---------------------------------------------------------------------------
  // Read mux and acknowledge; unmapped reads give zero.
  // ---------------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req && !d_hold;
      case (wb_adr_i)
        `NCPE_CTRL_OFS: wb_dat_o <= {23'h000000, wp_en, 8'h00};
        `NCPE_ADDR_OFS: wb_dat_o <= addr_q;
        `NCPE_STAT_OFS: wb_dat_o <= {9'h000, pcnt, 2'b00, dev_rst, pend_idle, loading,
                                     err, rb_q, !idle && (state != S_DATA), stat_q};
        default:        wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Input synchronisers: three stages, a change counts when two and three agree.
  // ---------------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rb_s <= 3'b111;
      rb_q <= 1'b1;
      io_a <= 8'h00;
      io_b <= 8'h00;
      io_c <= 8'h00;
    end
    else
    begin
      rb_s <= {rb_s[1:0], rb_n_i};
      io_a <= io_i;
      io_b <= io_a;
      io_c <= io_b;
      // Only the agreeing later stages update the clean busy level.
      if (rb_s[1] == rb_s[2])
        rb_q <= rb_s[2];
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer.
  // ---------------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state     <= S_IDLE;
      ph        <= 1'b0;
      tcnt      <= 4'h0;
      cmd_q     <= 8'h00;
      pend_cmd  <= 8'h00;
      acnt      <= 2'd0;
      addr_q    <= 32'h0000_0000;
      dat_q     <= 8'h00;
      stat_q    <= 8'h00;
      dcnt      <= 12'h000;
      pcnt      <= 7'h00;
      blk_q     <= 10'h000;
      loading   <= 1'b0;
      in_seq    <= 1'b0;
      pend_idle <= 1'b0;
      polling   <= 1'b0;
      dev_rst   <= 1'b0;
      err       <= 1'b0;
      wp_en     <= 1'b1;
    end
    else
    begin
      // Phase timing shared by all pin cycles.
      if (strobing || (state == S_STAT) || (state == S_TWB))
      begin
        // The bus gap runs its own full length, never a strobe phase length.
        if ((ph_end && (state != S_TWB)) || ((state == S_TWB) && (tcnt == WB_M1[3:0])))
        begin
          tcnt <= 4'h0;
          ph   <= !ph;
        end
        else
          tcnt <= tcnt + 4'h1;
      end

      // Software writes to the address register.
      if (wr && (wb_adr_i == `NCPE_ADDR_OFS) && idle)
        addr_q <= wb_dat_i;

      // Status read clears the refusal flag; a new refusal in the same cycle wins.
      if (req && !wb_we_i && (wb_adr_i == `NCPE_STAT_OFS))
        err <= 1'b0;

      // Control writes start operations; reset overrides the other operations, but a pin cycle completing in the same cycle still sets the state.
      if (c_wr)
      begin
        wp_en <= wb_dat_i[`NCPE_CTRL_WP_BIT];
        if (op == `NCPE_OP_RESET)
        begin
          if (go_rst)
          begin
            cmd_q     <= `NCPE_CMD_RESET;
            state     <= S_CMD;
            ph        <= 1'b0;
            tcnt      <= 4'h0;
            loading   <= 1'b0;
            in_seq    <= 1'b0;
            pend_idle <= 1'b0;
            polling   <= 1'b0;
            pcnt      <= 7'h00;
          end
          else
            err <= 1'b1;
        end
        else if (go_setup)
        begin
          // A new page of the sequence continues past pending programming.
          cmd_q   <= `NCPE_CMD_SETUP;
          state   <= S_CMD;
          acnt    <= 2'd0;
          blk_q   <= addr_q[31:22];
          in_seq  <= 1'b1;
          dev_rst <= 1'b0;
          dcnt    <= 12'h000;
        end
        else if (go_conf)
        begin
          cmd_q   <= (op == `NCPE_OP_CACHE) ? `NCPE_CMD_CACHE : `NCPE_CMD_LAST;
          state   <= S_CMD;
          loading <= 1'b0;
          pcnt    <= pcnt + 7'h01;
        end
        else if (go_erase || go_stat)
        begin
          // After a final cache confirm an erase polls the idle flag first.
          pend_cmd <= go_erase ? `NCPE_CMD_ERASE : `NCPE_CMD_STATUS;
          cmd_q    <= (go_erase && pend_idle) ? `NCPE_CMD_STATUS :
                      (go_erase ? `NCPE_CMD_ERASE : `NCPE_CMD_STATUS);
          polling  <= go_erase && pend_idle;
          acnt     <= 2'd2;
          dev_rst  <= 1'b0;
          state    <= S_CMD;
        end
        else if (op != `NCPE_OP_NONE)
          err <= 1'b1;
      end

      // Data bytes: accepted in the load phase while dcnt is below NCPE_MAX_BYTES, refused otherwise.
      if (d_wr && !d_hold)
      begin
        if ((state == S_DATA) && (dcnt < `NCPE_MAX_BYTES))
        begin
          dat_q <= wb_dat_i[7:0];
          state <= S_DOUT;
        end
        else
          err <= 1'b1;
      end

      // Pin cycle completions.
      case (state)
        S_CMD:
        begin
          if (cyc_done)
          begin
            if ((cmd_q == `NCPE_CMD_SETUP) || (cmd_q == `NCPE_CMD_ERASE))
              state <= S_ADDR;
            else if (cmd_q == `NCPE_CMD_STATUS)
              state <= S_STAT;
            else
              state <= S_TWB;
          end
        end
        S_ADDR:
        begin
          if (cyc_done)
          begin
            acnt <= acnt + 2'd1;
            if (acnt == 2'd3)
            begin
              if (cmd_q == `NCPE_CMD_ERASE)
              begin
                cmd_q <= `NCPE_CMD_ERCONF;
                state <= S_CMD;
              end
              else
              begin
                loading <= 1'b1;
                state   <= S_DATA;
              end
            end
          end
        end
        S_DOUT:
        begin
          if (cyc_done)
          begin
            dcnt  <= dcnt + 12'h001;
            state <= S_DATA;
          end
        end
        S_TWB:
        begin
          if (ph)
          begin
            ph    <= 1'b0;
            tcnt  <= 4'h0;
            state <= S_RB;
          end
        end
        S_RB:
        begin
          // Busy covers transfer, queued programming, erase or reset.
          if (rb_q)
          begin
            state <= S_IDLE;
            if (cmd_q == `NCPE_CMD_RESET)
              dev_rst <= 1'b1;
            if (cmd_q == `NCPE_CMD_CACHE)
              pend_idle <= 1'b1;
            else
            begin
              pend_idle <= 1'b0;
              if (cmd_q != `NCPE_CMD_RESET)
              begin
                in_seq <= 1'b0;
                pcnt   <= 7'h00;
              end
            end
          end
        end
        S_STAT:
        begin
          // Reserved bits are masked so the byte compares stably.
          if (!ph && ph_end)
            stat_q <= io_c & `NCPE_SR_RSV_MASK;
          if (cyc_done)
          begin
            if (polling && !stat_q[`NCPE_SR_IDLE_BIT])
              state <= S_STAT;
            else if (polling)
            begin
              polling   <= 1'b0;
              pend_idle <= 1'b0;
              in_seq    <= 1'b0;
              pcnt      <= 7'h00;
              cmd_q     <= pend_cmd;
              state     <= S_CMD;
            end
            else
              state <= S_IDLE;
          end
        end
        default:
        begin
        end
      endcase
    end
  end

endmodule // ncpe_host

`default_nettype wire

/* rtl/ncpe_regs.vh */
`ifndef NCPE_REGS_VH
`define NCPE_REGS_VH
// -----------------------------------------------------------------------------
// Register offsets of the controller (byte addresses on the Wishbone bus).
// -----------------------------------------------------------------------------
`define NCPE_CTRL_OFS     8'h00
`define NCPE_ADDR_OFS     8'h04
`define NCPE_DATA_OFS     8'h08
`define NCPE_STAT_OFS     8'h0c
// Control register fields.
`define NCPE_CTRL_OP_LSB  0
`define NCPE_CTRL_OP_MSB  2
`define NCPE_CTRL_WP_BIT  8
`define NCPE_CTRL_RESET   32'h0000_0100
// Operation codes written into the control register.
`define NCPE_OP_NONE      3'h0
`define NCPE_OP_SETUP     3'h1
`define NCPE_OP_CACHE     3'h2
`define NCPE_OP_LAST      3'h3
`define NCPE_OP_ERASE     3'h4
`define NCPE_OP_RESET     3'h5
`define NCPE_OP_STATUS    3'h6
// Status register fields.
`define NCPE_ST_BUSY_BIT  8
`define NCPE_ST_RB_BIT    9
`define NCPE_ST_ERR_BIT   10
`define NCPE_ST_LOAD_BIT  11
`define NCPE_ST_PEND_BIT  12
`define NCPE_ST_RST_BIT   13
`define NCPE_ST_PG_LSB    16
// -----------------------------------------------------------------------------
// Device command bytes and status byte fields.
// -----------------------------------------------------------------------------
`define NCPE_CMD_SETUP    8'h80
`define NCPE_CMD_CACHE    8'h15
`define NCPE_CMD_LAST     8'h10
`define NCPE_CMD_ERASE    8'h60
`define NCPE_CMD_ERCONF   8'hd0
`define NCPE_CMD_RESET    8'hff
`define NCPE_CMD_STATUS   8'h70
`define NCPE_SR_IDLE_BIT  5
`define NCPE_SR_RSV_MASK  8'he3
// -----------------------------------------------------------------------------
// Sequence limits.
// -----------------------------------------------------------------------------
`define NCPE_MAX_BYTES    12'd2112
`define NCPE_MAX_PAGES    7'd64
// -----------------------------------------------------------------------------
// Pin timing, in ns and in 100 MHz cycles (least times round up).
// -----------------------------------------------------------------------------
`define NCPE_CLK_NS       10
`define NCPE_T_WLO_NS     30
`define NCPE_T_WHI_NS     30
`define NCPE_T_RLO_NS     60
`define NCPE_T_WB_NS      100
`define NCPE_T_WLO_CYC    ((`NCPE_T_WLO_NS + `NCPE_CLK_NS - 1) / `NCPE_CLK_NS)
`define NCPE_T_WHI_CYC    ((`NCPE_T_WHI_NS + `NCPE_CLK_NS - 1) / `NCPE_CLK_NS)
`define NCPE_T_RLO_CYC    ((`NCPE_T_RLO_NS + `NCPE_CLK_NS - 1) / `NCPE_CLK_NS)
`define NCPE_T_WB_CYC     ((`NCPE_T_WB_NS + `NCPE_CLK_NS - 1) / `NCPE_CLK_NS)
`endif

/* verification/ncpe_host_chk.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ncpe_regs.vh"
// ------------------------------------------------------------
// Pin and bus checker for the flash host controller.
// ------------------------------------------------------------
module ncpe_host_chk
(
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Wishbone side.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Flash pins.
  input wire logic        ce_n_o,
  input wire logic        cle_o,
  input wire logic        ale_o,
  input wire logic        we_n_o,
  input wire logic        re_n_o,
  input wire logic        wp_n_o,
  input wire logic [7:0]  io_o,
  input wire logic        io_oe_o,
  input wire logic        rb_n_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Write strobe phases: three cycles low, then three high.
  sequence s_wr_low;  !we_n_o [*3]; endsequence
  sequence s_wr_high; we_n_o [*3]; endsequence
  // Erase walk after the setup byte: two block address bytes, then confirm.
  sequence s_erase_tail; ##3 ale_o ##6 ale_o ##6 (cle_o && io_o == `NCPE_CMD_ERCONF); endsequence
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_request: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i && $past(wb_stb_i))
    else $error("ack without request");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h10 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_wp_follows: assert property (wb_ack_o && wb_we_i && wb_adr_i == `NCPE_CTRL_OFS
    |=> wp_n_o == !$past(wb_dat_i[8])) else $error("protect pin wrong");
  a_strobe_shape: assert property ($fell(we_n_o) |-> s_wr_low ##1 s_wr_high)
    else $error("write strobe shape wrong");
  a_latch_stable: assert property ($rose(we_n_o) |-> $stable(io_o) && $stable(cle_o)
    && $stable(ale_o) && io_oe_o) else $error("bus moved at latch edge");
  a_latch_excl: assert property (!we_n_o |-> !ce_n_o && io_oe_o && !(cle_o && ale_o))
    else $error("bad write cycle framing");
  a_read_release: assert property (!re_n_o |-> !io_oe_o && !ce_n_o && we_n_o)
    else $error("bus driven during status read");
  a_read_low: assert property ($fell(re_n_o) |-> !re_n_o [*6])
    else $error("read strobe too short");
  a_busy_quiet: assert property ($fell(we_n_o) && !$past(rb_n_i) && !$past(rb_n_i, 2)
    && !$past(rb_n_i, 3) |-> cle_o && io_o == `NCPE_CMD_RESET) else $error("command sent while busy");
  a_erase_walk: assert property ($rose(we_n_o) && cle_o && io_o == `NCPE_CMD_ERASE
    |-> s_erase_tail) else $error("erase sequence malformed");
endmodule // ncpe_host_chk
bind ncpe_host ncpe_host_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ce_n_o(ce_n_o), .cle_o(cle_o), .ale_o(ale_o),
  .we_n_o(we_n_o), .re_n_o(re_n_o), .wp_n_o(wp_n_o), .io_o(io_o), .io_oe_o(io_oe_o),
  .rb_n_i(rb_n_i));
`default_nettype wire

/* verification/ncpe_dev.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Behavioural flash device: cache program, erase, reset, status.
// ------------------------------------------------------------
module ncpe_dev #(parameter int XFER = 20, PROG = 60, ERASE = 80, RST = 15)
(
  // Clock used only as a time base.
  input wire logic       clk_i,
  // Pins from the host, plus fail_i driven by the testbench.
  input wire logic       ce_n_i,
  input wire logic       cle_i,
  input wire logic       ale_i,
  input wire logic       we_n_i,
  input wire logic       re_n_i,
  input wire logic       wp_n_i,
  input wire logic [7:0] io_i,
  input wire logic       fail_i,
  // Pins to the host.
  output logic [7:0]     io_o,
  output logic           rb_n_o
);
  int xfer = 0, prog = 0, er = 0, rs = 0, acnt = 0;           // Busy counters and address byte counter.
  int nbytes = 0, pages = 0, nerase = 0, nres = 0, viol = 0;  // Observed traffic.
  logic [7:0] row0 = 8'h0, row1 = 8'h0, last = 8'h0;          // Row bytes, last bus value.
  logic [9:0] blk = 10'h0;                                    // Last erased block.
  logic we_q = 1'b1, load = 1'b0, smode = 1'b0, rcond = 1'b1, pfail = 1'b0, cfail = 1'b0;
  wire rdy = (xfer == 0) && (er == 0) && (rs == 0);
  wire idle = rdy && (prog == 0);
  // Reserved bits are driven as zero.
  wire [7:0] sr = {wp_n_i, rdy, idle, 3'b000, pfail, cfail};
  // Status shows live in status mode while selected and read; otherwise the bus toggles.
  assign io_o = (smode && !ce_n_i && !re_n_i) ? sr : ~last;
  assign rb_n_o = rdy;
  // Latch command, address and data on the rising write strobe.
  always @(posedge clk_i)
  begin
    last <= io_o;
    we_q <= we_n_i;
    if (xfer > 0) xfer <= xfer - 1;
    if (prog > 0) prog <= prog - 1;
    if (er > 0) er <= er - 1;
    if (rs > 0) rs <= rs - 1;
    if (!we_q && we_n_i && !ce_n_i)
    begin
      if (cle_i && (rdy || io_i == 8'hff || io_i == 8'h70))
      begin
        smode <= (io_i == 8'h70);
        case (io_i)
          8'h80: begin acnt <= 4; load <= 1'b1; rcond <= 1'b0; end
          // The wait for the page buffer stretches the transfer.
          8'h15, 8'h10: if (load)
          begin
            xfer <= XFER + prog + ((io_i == 8'h10) ? PROG : 0);
            prog <= XFER + prog + PROG;
            pages <= pages + 1;
            pfail <= cfail;
            cfail <= fail_i;
            load <= 1'b0;
          end
          8'h60: begin viol <= viol + int'(prog != 0); acnt <= 2; rcond <= 1'b0; end
          8'hd0: begin er <= ERASE; blk <= {row1, row0[7:6]}; nerase <= nerase + 1;
            cfail <= fail_i; pfail <= 1'b0; end
          8'hff: if (!rcond)
          begin
            xfer <= 0; prog <= 0; er <= 0; rs <= RST;
            load <= 1'b0; pfail <= 1'b0; cfail <= 1'b0; rcond <= 1'b1; nres <= nres + 1;
          end
          default: ;
        endcase
      end
      else if (ale_i)
      begin
        acnt <= acnt - 1;
        if (acnt == 2) row0 <= io_i;
        if (acnt == 1) row1 <= io_i;
      end
      else if (load && !cle_i) nbytes <= nbytes + 1;
    end
  end
endmodule // ncpe_dev
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ncpe_regs.vh"
// ------------------------------------------------------------
// Register-level tests of the flash host controller.
// ------------------------------------------------------------
module tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, fail = 1'b0;
  logic [7:0]  adr = 8'h00;                 // Bus address.
  logic [3:0]  sel = 4'h0;                  // Byte selects.
  logic [31:0] wdat = 32'h0, rdat;          // Write data, last read data.
  wire  [31:0] wb_dat_o;
  wire  [7:0]  io_o, io_i;
  wire         wb_ack_o, ce_n, cle, ale, we_n, re_n, wp_n, io_oe, rb_n;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  ncpe_host uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ce_n_o(ce_n), .cle_o(cle), .ale_o(ale), .we_n_o(we_n), .re_n_o(re_n), .wp_n_o(wp_n),
    .io_o(io_o), .io_oe_o(io_oe), .io_i(io_i), .rb_n_i(rb_n));
  ncpe_dev dev (.clk_i(clk_i), .ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
    .re_n_i(re_n), .wp_n_i(wp_n), .io_i(io_o), .fail_i(fail), .io_o(io_i), .rb_n_o(rb_n));
  initial forever #5 clk_i = ~clk_i;
  // One classic Wishbone cycle; read data is taken at the ack edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic op(input logic [31:0] c);
    wb(1'b1, `NCPE_CTRL_OFS, c);
  endtask
  // Poll the status register until one bit shows the wanted level.
  task automatic wait_bit(input int b, input logic v);
    int i;
    i = 0;
    do begin wb(1'b0, `NCPE_STAT_OFS, 32'h0); i++; end while (rdat[b] !== v && i < 3000);
    if (rdat[b] !== v)
    begin
      miscompares++;
      $display("BAD stat_wait expected %b seen %b", v, rdat[b]);
    end
  endtask
  // Poll the status register until the controller is no longer busy.
  task automatic wait_idle;
    wait_bit(8, 1'b0);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 40000) begin miscompares++; test_done; end
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `NCPE_STAT_OFS, 32'h0);
    chk("stat_flags", 32'h200, rdat & 32'h0f00);
    chk("wp_pin", 32'h0, {31'h0, wp_n});
    wb(1'b0, 8'h10, 32'hffff_ffff);
    chk("unmapped", 32'h0, rdat);
    $display("test reset done");
    // Erase passing, then failing; reserved bits must read zero.
    for (int k = 0; k < 2; k++)
    begin
      fail <= k[0];
      wb(1'b1, `NCPE_ADDR_OFS, 32'h5a5c_0000);
      op(32'h4);
      wait_idle;
      chk("blk", 32'h169, 32'(dev.blk));
      op(32'h6);
      wait_idle;
      chk("status", 32'he0 | k, 32'(rdat[7:0]));
    end
    $display("test erase done");
    // Two cached pages: first fails, second passes.
    wb(1'b1, `NCPE_ADDR_OFS, 32'h5a40_0000);
    fail <= 1'b1;
    op(32'h1);
    wait_idle;
    for (int k = 0; k < 3; k++) wb(1'b1, `NCPE_DATA_OFS, 32'(k));
    wait_idle;
    op(32'h2);
    wait_idle;
    chk("pages_q", 32'h1, 32'(rdat[22:16]));
    fail <= 1'b0;
    op(32'h1);
    wait_idle;
    for (int k = 0; k < 2; k++) wb(1'b1, `NCPE_DATA_OFS, 32'(k));
    wait_idle;
    op(32'h3);
    wait_idle;
    chk("pages", 32'h2, 32'(dev.pages));
    chk("bytes", 32'h5, 32'(dev.nbytes));
    op(32'h6);
    wait_idle;
    chk("status", 32'he2, 32'(rdat[7:0]));
    // A sequence ended with 15h, then an erase that must wait for idle.
    op(32'h1);
    wait_idle;
    wb(1'b1, `NCPE_DATA_OFS, 32'h5);
    wait_idle;
    op(32'h2);
    wait_idle;
    chk("pend", 32'h1, 32'(rdat[12]));
    op(32'h4);
    wait_idle;
    chk("viol", 32'h0, 32'(dev.viol));
    chk("erases", 32'h3, 32'(dev.nerase));
    $display("test cache done");
    // Confirm with no page open is refused; the error clears on read.
    op(32'h2);
    wb(1'b0, `NCPE_STAT_OFS, 32'h0);
    chk("err", 32'h1, 32'(rdat[10]));
    wb(1'b0, `NCPE_STAT_OFS, 32'h0);
    chk("err_clr", 32'h0, 32'(rdat[10]));
    // Reset, then a second reset that must be refused.
    op(32'h5);
    wait_idle;
    chk("resets", 32'h1, 32'(dev.nres));
    chk("rst_cond", 32'h1, 32'(rdat[13]));
    op(32'h5);
    wb(1'b0, `NCPE_STAT_OFS, 32'h0);
    chk("err", 32'h1, 32'(rdat[10]));
    chk("resets", 32'h1, 32'(dev.nres));
    // Reset aborts a running erase.
    op(32'h4);
    wait_bit(9, 1'b0);
    op(32'h5);
    wait_idle;
    chk("resets", 32'h2, 32'(dev.nres));
    // Protected device reports a clear protect flag.
    op(32'h106);
    wait_idle;
    chk("status_wp", 32'h60, 32'(rdat[7:0]));
    chk("wp_pin", 32'h0, {31'h0, wp_n});
    $display("test reset cmd done");
    test_done;
  end
endmodule // tb_top
`default_nettype wire
